// ---- tcc_cfg.svh ----
`ifndef TCC_CFG_SVH
`define TCC_CFG_SVH

// ==========================================================
// Register byte offsets
`define TCC_OFS_CTRL_A 8'h00
`define TCC_OFS_CTRL_B 8'h04
`define TCC_OFS_COUNT 8'h08
`define TCC_OFS_CMP_A 8'h0C
`define TCC_OFS_CMP_B 8'h10
`define TCC_OFS_MASK 8'h14
`define TCC_OFS_FLAG 8'h18
`define TCC_OFS_POWER 8'h1C
`define TCC_OFS_PORT 8'h20

// ==========================================================
// Field positions
`define TCC_COMA_HI 7
`define TCC_COMA_LO 6
`define TCC_COMB_HI 5
`define TCC_COMB_LO 4
`define TCC_FOCA_BIT 7
`define TCC_FOCB_BIT 6
`define TCC_WGM2_BIT 3
`define TCC_OVF_BIT 0
`define TCC_CFA_BIT 1
`define TCC_CFB_BIT 2
`define TCC_PWROFF_BIT 0

// ==========================================================
// Values and reset values
`define TCC_BOTTOM 8'h00
`define TCC_MAX 8'hFF
`define TCC_RST_BYTE 8'h00
`define TCC_RST_PWROFF 1'b0
`define TCC_PRESC_BITS 10

`endif

// ---- tcc_clk_sel.sv ----
`timescale 1ns/1ns
`include "tcc_cfg.svh"
module tcc_clk_sel (
    input wire logic pclk,
    input wire logic presetn,
    input wire tcc_pkg::tcc_cs_t clock_select_field,
    input wire logic power_off,
    input wire logic external_count_pin,
    output logic timer_tick_clock
);
    import tcc_pkg::*;

    logic [`TCC_PRESC_BITS-1:0] presc_r;
    logic [2:0] pin_sync_r;
    logic ext_rise_r;
    logic ext_fall_r;
    logic ext_lvl_r;
    logic src_w;

    // ==========================================================
    // Prescaler and pin synchroniser
    // Free-running prescaler: ticks of different taps stay phase-aligned
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            presc_r <= '0;
            pin_sync_r <= 3'h0;
        end else begin
            presc_r <= presc_r + 1'b1;
            pin_sync_r <= {pin_sync_r[1:0], external_count_pin};
        end
    end

    assign src_w = (clock_select_field == TCC_CS_DIV1) ? 1'b1 :
                   (clock_select_field == TCC_CS_DIV8) ? (presc_r[2:0] == 3'h7) :
                   (clock_select_field == TCC_CS_DIV64) ? (presc_r[5:0] == 6'h3F) :
                   (clock_select_field == TCC_CS_DIV256) ? (presc_r[7:0] == 8'hFF) :
                   (clock_select_field == TCC_CS_DIV1024) ? (&presc_r) :
                   (clock_select_field == TCC_CS_EXT_FALL) ? ext_fall_r :
                   (clock_select_field == TCC_CS_EXT_RISE) ? ext_rise_r : 1'b0;

    // Debounced level follows stage three once stage two agrees
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ext_lvl_r <= 1'b0;
            ext_rise_r <= 1'b0;
            ext_fall_r <= 1'b0;
        end else begin
            ext_rise_r <= (pin_sync_r[1] == pin_sync_r[2]) & pin_sync_r[2] & ~ext_lvl_r;
            ext_fall_r <= (pin_sync_r[1] == pin_sync_r[2]) & ~pin_sync_r[2] & ext_lvl_r;
            if (pin_sync_r[1] == pin_sync_r[2]) begin
                ext_lvl_r <= pin_sync_r[2];
            end
        end
    end

    // Stopped when nothing is selected or the module is powered down
    assign timer_tick_clock = src_w & ~power_off;
endmodule

// ---- tcc_cmp_ch.sv ----
`timescale 1ns/1ns
`include "tcc_cfg.svh"
module tcc_cmp_ch (
    input wire logic pclk,
    input wire logic presetn,
    tcc_cmp_if.chan ch
);
    import tcc_pkg::*;

    logic [7:0] buf_r;
    logic [7:0] ocr_r;
    logic oc_r;
    logic oc_nxt;
    logic eq_w;
    logic act_w;

    function automatic logic apply_com(input tcc_com_t com, input logic cur, input logic tgl);
        case (com)
            2'h1: apply_com = tgl ? ~cur : cur;
            2'h2: apply_com = 1'b0;
            2'h3: apply_com = 1'b1;
            default: apply_com = cur;
        endcase
    endfunction

    // ==========================================================
    // Comparator and latch action
    assign eq_w = (ch.count == ocr_r);
    assign ch.match = ch.tick & eq_w & ~ch.blk;
    assign act_w = ch.match | (ch.force_strobe & ~ch.pwm);
    assign ch.active = ocr_r;
    assign ch.readback = ch.pwm ? buf_r : ocr_r;
    assign ch.latch = oc_r;

    // PWM polarity: mode 3 inverts mode 2; phase correct flips on the down slope
    always_comb begin
        oc_nxt = oc_r;
        if (!ch.pwm) begin
            if (act_w) begin
                oc_nxt = apply_com(ch.com, oc_r, 1'b1);
            end
        end else if (ch.com == 2'h1) begin
            if (ch.match && ch.allow_toggle) begin
                oc_nxt = ~oc_r;
            end
        end else if (ch.com[1]) begin
            if (ch.match) begin
                oc_nxt = ch.com[0] ^ (~ch.fast & ch.down);
            end else if (ch.fast && ch.bottom_ev) begin
                oc_nxt = ~ch.com[0];
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            buf_r <= `TCC_RST_BYTE;
            ocr_r <= `TCC_RST_BYTE;
            oc_r <= 1'b0;
        end else begin
            if (ch.wr_en) begin
                buf_r <= ch.wr_data;
            end
            if (ch.wr_en && !ch.pwm) begin
                ocr_r <= ch.wr_data;
            end else if (ch.pwm && ch.update) begin
                ocr_r <= buf_r;
            end
            oc_r <= oc_nxt;
        end
    end
endmodule

// ---- tcc_cmp_if.sv ----
`timescale 1ns/1ns
interface tcc_cmp_if;
    import tcc_pkg::*;
    logic [7:0] count;
    logic tick;
    logic blk;
    logic pwm;
    logic fast;
    logic down;
    logic allow_toggle;
    tcc_com_t com;
    logic force_strobe;
    logic wr_en;
    logic [7:0] wr_data;
    logic update;
    logic bottom_ev;
    logic match;
    logic [7:0] active;
    logic [7:0] readback;
    logic latch;

    modport core (
        output count, tick, blk, pwm, fast, down, allow_toggle, com, force_strobe,
        output wr_en, wr_data, update, bottom_ev,
        input match, active, readback, latch
    );
    modport chan (
        input count, tick, blk, pwm, fast, down, allow_toggle, com, force_strobe,
        input wr_en, wr_data, update, bottom_ev,
        output match, active, readback, latch
    );
endinterface

// ---- tcc_pins_model.sv ----
`timescale 1ns/1ns
// ==========================================
// Far side: count input pin, pull-up on pin A
module tcc_pins_model (
    input wire logic pclk,
    input wire logic pin_a,
    input wire logic oe_n_a,
    output logic level_a,
    output logic external_count_pin
);
    // Released pin floats to the pull-up
    assign level_a = oe_n_a ? 1'b1 : pin_a;
    initial external_count_pin = 1'b0;
    // Slow edges so the synchroniser sees each one
    task automatic pulses(input int n);
        repeat (n) begin
            repeat (10) @(posedge pclk);
            external_count_pin <= 1'b1;
            repeat (10) @(posedge pclk);
            external_count_pin <= 1'b0;
        end
    endtask
endmodule

// ---- tcc_pkg.sv ----
package tcc_pkg;
    typedef enum logic [2:0] {
        TCC_WGM_NORMAL = 3'h0,
        TCC_WGM_PC_MAX = 3'h1,
        TCC_WGM_CTC = 3'h2,
        TCC_WGM_FAST_MAX = 3'h3,
        TCC_WGM_RSV4 = 3'h4,
        TCC_WGM_PC_OCR = 3'h5,
        TCC_WGM_RSV6 = 3'h6,
        TCC_WGM_FAST_OCR = 3'h7
    } tcc_wgm_t;

    typedef enum logic [2:0] {
        TCC_CS_STOP = 3'h0,
        TCC_CS_DIV1 = 3'h1,
        TCC_CS_DIV8 = 3'h2,
        TCC_CS_DIV64 = 3'h3,
        TCC_CS_DIV256 = 3'h4,
        TCC_CS_DIV1024 = 3'h5,
        TCC_CS_EXT_FALL = 3'h6,
        TCC_CS_EXT_RISE = 3'h7
    } tcc_cs_t;

    typedef logic [1:0] tcc_com_t;
endpackage

// ---- tcc_top.sv ----
// The address map and the APB interface to the registers are this design's own decisions.
`timescale 1ns/1ns
`include "tcc_cfg.svh"
// Contract
// (R1) Eight-bit count and compare registers, shared comparator; each tcc_cmp_ch instance here has its own comparator
// (R2) Bottom 0x00, max 0xFF, top per mode
// (R3) Clock select zero stops the counter
// (R4) Tick from prescaler or external pin edge
// (R5) Each tick clears, increments or decrements count
// (R6) CPU count write beats clear and count
// (R7) Three-bit waveform mode split over two registers
// (R8) Equality sets compare flag on that tick
// (R9) Flag cleared by interrupt or writing one
// (R10) Flags visible; each masked onto own request
// (R11) Overflow flag set per waveform mode
// (R12) PWM modes double buffer compare values
// (R13) CPU reaches buffer or active register accordingly
// (R14) Force updates latch only, non-PWM modes
// (R15) Count write blocks matches next tick
// (R16) Software avoids writing count equal compare
// (R17) Software presets latch before enabling pin
// (R18) Output mode change acts at once
// (R19) Latches survive mode change, reset clears
// (R20) Nonzero output mode overrides port data
// (R21) Latch reaches pin only when direction output
// (R22) Power-off bit set halts the timer
// (R23) Mode zero counts up and wraps
// (R24) Output mode zero leaves latch alone
module tcc_top (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic external_count_pin,
    input wire logic [2:0] irq_ack,
    output logic [2:0] irq,
    output logic compare_output_a,
    output logic compare_output_a_oe_n,
    output logic compare_output_b,
    output logic compare_output_b_oe_n
);
    import tcc_pkg::*;

    tcc_cmp_if cha ();
    tcc_cmp_if chb ();

    logic [7:0] control_reg_a_r;
    logic [7:0] control_reg_b_r;
    logic [7:0] count_value_r;
    logic [7:0] count_value_nxt;
    logic [2:0] timer_mask_reg_r;
    logic [2:0] timer_flag_reg_r;
    logic [2:0] timer_flag_reg_nxt;
    logic timer_power_off_bit_r;
    logic [3:0] port_reg_r;
    logic dir_down_r;
    logic dir_down_nxt;
    logic blk_r;
    logic [31:0] prdata_r;
    logic pready_r;
    logic pslverr_r;
    logic [2:0] irq_r;
    logic [1:0] pin_r;
    logic [1:0] pin_oe_n_r;

    // ==========================================================
    // APB decode
    logic setup_w;
    logic wr_w;
    logic mapped_w;
    logic wr_cnt_w;
    logic [31:0] rdata_w;

    assign setup_w = psel & ~penable;
    assign wr_w = psel & penable & pready_r & pwrite;
    assign mapped_w = (paddr[1:0] == 2'h0) && (paddr <= `TCC_OFS_PORT);
    assign wr_cnt_w = wr_w && (paddr == `TCC_OFS_COUNT);

    function automatic logic wr_to(input logic wr, input logic [7:0] a, input logic [7:0] o);
        wr_to = wr && (a == o);
    endfunction

    always_comb begin
        rdata_w = 32'h0000_0000;
        case (paddr)
            `TCC_OFS_CTRL_A: rdata_w[7:0] = control_reg_a_r;
            `TCC_OFS_CTRL_B: rdata_w[7:0] = {2'h0, control_reg_b_r[5:0]};
            `TCC_OFS_COUNT: rdata_w[7:0] = count_value_r;
            `TCC_OFS_CMP_A: rdata_w[7:0] = cha.readback; // R13
            `TCC_OFS_CMP_B: rdata_w[7:0] = chb.readback;
            `TCC_OFS_MASK: rdata_w[2:0] = timer_mask_reg_r;
            `TCC_OFS_FLAG: rdata_w[2:0] = timer_flag_reg_r; // R10
            `TCC_OFS_POWER: rdata_w[0] = timer_power_off_bit_r;
            `TCC_OFS_PORT: rdata_w[3:0] = port_reg_r;
            default: rdata_w = 32'h0000_0000;
        endcase
    end

    // One wait-free access phase: pready rises on the cycle after setup
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready_r <= 1'b0;
            pslverr_r <= 1'b0;
            prdata_r <= 32'h0000_0000;
        end else begin
            pready_r <= setup_w;
            pslverr_r <= setup_w & ~mapped_w;
            if (setup_w) begin
                prdata_r <= rdata_w;
            end
        end
    end

    // ==========================================================
    // Control registers
    tcc_wgm_t wgm_w;
    tcc_cs_t cs_w;
    logic pwm_w;
    logic fast_w;
    logic tick_w;

    assign wgm_w = tcc_wgm_t'({control_reg_b_r[`TCC_WGM2_BIT], control_reg_a_r[1:0]}); // R7
    assign cs_w = tcc_cs_t'(control_reg_b_r[2:0]);
    assign pwm_w = control_reg_a_r[0]; // R12
    assign fast_w = control_reg_a_r[1];

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            control_reg_a_r <= `TCC_RST_BYTE;
            control_reg_b_r <= `TCC_RST_BYTE;
            timer_mask_reg_r <= 3'h0;
            timer_power_off_bit_r <= `TCC_RST_PWROFF;
            port_reg_r <= 4'h0;
        end else begin
            if (wr_to(wr_w, paddr, `TCC_OFS_CTRL_A)) begin
                control_reg_a_r <= pwdata[7:0]; // R18
            end
            // Force bits are strobes and never stored
            if (wr_to(wr_w, paddr, `TCC_OFS_CTRL_B)) begin
                control_reg_b_r <= {2'h0, pwdata[5:0]};
            end
            if (wr_to(wr_w, paddr, `TCC_OFS_MASK)) begin
                timer_mask_reg_r <= pwdata[2:0];
            end
            if (wr_to(wr_w, paddr, `TCC_OFS_POWER)) begin
                timer_power_off_bit_r <= pwdata[`TCC_PWROFF_BIT];
            end
            if (wr_to(wr_w, paddr, `TCC_OFS_PORT)) begin
                port_reg_r <= pwdata[3:0];
            end
        end
    end

    tcc_clk_sel u_clk_sel (
        .pclk(pclk),
        .presetn(presetn),
        .clock_select_field(cs_w), // R3 R4
        .power_off(timer_power_off_bit_r), // R22
        .external_count_pin(external_count_pin),
        .timer_tick_clock(tick_w)
    );

    // ==========================================================
    // Counter unit
    logic [7:0] top_w;
    logic at_top_w;
    logic at_bot_w;
    logic top_ev_w;
    logic ovf_w;

    assign top_w = (wgm_w == TCC_WGM_CTC || control_reg_b_r[`TCC_WGM2_BIT]) ?
                   cha.active : `TCC_MAX; // R2
    assign at_top_w = (count_value_r == top_w);
    assign at_bot_w = (count_value_r == `TCC_BOTTOM);
    assign top_ev_w = tick_w & pwm_w & at_top_w;
    // Overflow point: wrap from max, top in fast PWM, bottom in phase correct
    assign ovf_w = tick_w & (pwm_w ? (fast_w ? at_top_w : at_bot_w) :
                   ((count_value_r == `TCC_MAX) & ~(cha.match & wgm_w == TCC_WGM_CTC))); // R11

    always_comb begin
        count_value_nxt = count_value_r;
        dir_down_nxt = dir_down_r;
        if (wr_cnt_w) begin
            count_value_nxt = pwdata[7:0]; // R6
        end else if (tick_w) begin
            if (wgm_w == TCC_WGM_CTC && cha.match) begin
                count_value_nxt = `TCC_BOTTOM;
            end else if (pwm_w && fast_w && at_top_w) begin
                count_value_nxt = `TCC_BOTTOM;
            end else if (pwm_w && !fast_w) begin
                // Phase correct turns at top and bottom
                if (dir_down_r && at_bot_w) begin
                    dir_down_nxt = 1'b0;
                end else if (!dir_down_r && at_top_w) begin
                    dir_down_nxt = 1'b1;
                end
                count_value_nxt = dir_down_nxt ? count_value_r - 8'h01 : count_value_r + 8'h01;
            end else begin
                count_value_nxt = count_value_r + 8'h01; // R5 R23
            end
        end
        if (!(pwm_w && !fast_w)) begin
            dir_down_nxt = 1'b0;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            count_value_r <= `TCC_BOTTOM;
            dir_down_r <= 1'b0;
            blk_r <= 1'b0;
        end else begin
            count_value_r <= count_value_nxt;
            dir_down_r <= dir_down_nxt;
            // Held until the next tick, so a stopped timer still blocks
            blk_r <= wr_cnt_w | (blk_r & ~tick_w); // R15
        end
    end

    // ==========================================================
    // Compare channels
    assign cha.count = count_value_r;
    assign cha.tick = tick_w;
    assign cha.blk = blk_r;
    assign cha.pwm = pwm_w;
    assign cha.fast = fast_w;
    assign cha.down = dir_down_r;
    assign cha.allow_toggle = control_reg_b_r[`TCC_WGM2_BIT];
    assign cha.com = control_reg_a_r[`TCC_COMA_HI:`TCC_COMA_LO];
    assign cha.force_strobe = wr_to(wr_w, paddr, `TCC_OFS_CTRL_B) & pwdata[`TCC_FOCA_BIT]; // R14
    assign cha.wr_en = wr_to(wr_w, paddr, `TCC_OFS_CMP_A);
    assign cha.wr_data = pwdata[7:0];
    assign cha.update = top_ev_w & ~fast_w | top_ev_w & fast_w; // R12
    assign cha.bottom_ev = top_ev_w;

    assign chb.count = count_value_r;
    assign chb.tick = tick_w;
    assign chb.blk = blk_r;
    assign chb.pwm = pwm_w;
    assign chb.fast = fast_w;
    assign chb.down = dir_down_r;
    assign chb.allow_toggle = 1'b0;
    assign chb.com = control_reg_a_r[`TCC_COMB_HI:`TCC_COMB_LO];
    assign chb.force_strobe = wr_to(wr_w, paddr, `TCC_OFS_CTRL_B) & pwdata[`TCC_FOCB_BIT]; // R14
    assign chb.wr_en = wr_to(wr_w, paddr, `TCC_OFS_CMP_B);
    assign chb.wr_data = pwdata[7:0];
    assign chb.update = top_ev_w;
    assign chb.bottom_ev = top_ev_w;

    tcc_cmp_ch u_ch_a (
        .pclk(pclk),
        .presetn(presetn),
        .ch(cha) // R1 R19 R24
    );

    tcc_cmp_ch u_ch_b (
        .pclk(pclk),
        .presetn(presetn),
        .ch(chb)
    );

    // ==========================================================
    // Flags, requests and pins
    logic [2:0] flag_set_w;
    logic [2:0] flag_clr_w;
    logic [1:0] com_on_w;

    assign flag_set_w = {chb.match, cha.match, ovf_w}; // R8
    assign flag_clr_w = irq_ack | ({3{wr_to(wr_w, paddr, `TCC_OFS_FLAG)}} & pwdata[2:0]); // R9
    // Set beats a clear in the same cycle so no event is lost
    assign timer_flag_reg_nxt = (timer_flag_reg_r & ~flag_clr_w) | flag_set_w;
    assign com_on_w = {|chb.com, |cha.com};

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            timer_flag_reg_r <= 3'h0;
            irq_r <= 3'h0;
            pin_r <= 2'h0;
            pin_oe_n_r <= 2'h3;
        end else begin
            timer_flag_reg_r <= timer_flag_reg_nxt;
            irq_r <= timer_flag_reg_nxt & timer_mask_reg_r; // R10
            pin_r[0] <= com_on_w[0] ? cha.latch : port_reg_r[0]; // R20
            pin_r[1] <= com_on_w[1] ? chb.latch : port_reg_r[1];
            pin_oe_n_r <= ~port_reg_r[3:2]; // R21
        end
    end

    assign prdata = prdata_r;
    assign pready = pready_r;
    assign pslverr = pslverr_r;
    assign irq = irq_r;
    assign compare_output_a = pin_r[0];
    assign compare_output_b = pin_r[1];
    assign compare_output_a_oe_n = pin_oe_n_r[0];
    assign compare_output_b_oe_n = pin_oe_n_r[1];

    // ==========================================================
    // Checks
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    sequence cnt_write_s;
        wr_cnt_w;
    endsequence

    write_prio_a: assert property (cnt_write_s |=> count_value_r == $past(pwdata[7:0])) // R6
        else $error("count write lost to counting");
    stop_hold_a: assert property ((cs_w == TCC_CS_STOP) && !wr_cnt_w |=> $stable(count_value_r)) // R3
        else $error("counter moved while stopped");
    flag_set_a: assert property (cha.match |=> timer_flag_reg_r[`TCC_CFA_BIT]) // R8
        else $error("compare flag A not set on match");
    flag_clear_a: assert property (irq_ack[2] && !chb.match |=> !timer_flag_reg_r[2]) // R9
        else $error("compare flag B not cleared");
    irq_mask_a: assert property (##1 irq_r == (timer_flag_reg_r & $past(timer_mask_reg_r))) // R10
        else $error("request differs from masked flag");
    match_block_a: assert property (cnt_write_s ##1 tick_w |-> !cha.match && !chb.match) // R15
        else $error("match not blocked after count write");
    normal_wrap_a: assert property (wgm_w == TCC_WGM_NORMAL && tick_w && !wr_cnt_w
        && count_value_r == `TCC_MAX |=> count_value_r == `TCC_BOTTOM && timer_flag_reg_r[0]) // R23
        else $error("normal mode wrap or overflow wrong");
    power_off_a: assert property (timer_power_off_bit_r |-> !tick_w) // R22
        else $error("tick while powered down");
    pin_dir_a: assert property (!port_reg_r[2] |=> compare_output_a_oe_n) // R21
        else $error("pin A driven with input direction");
endmodule

// ---- timer_counter_compare_core_bench.sv ----
`timescale 1ns/1ns
`include "tcc_cfg.svh"
module timer_counter_compare_core_bench;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, last_err;
    logic ext_pin, level_a, pin_a, oe_n_a, pin_b, oe_n_b;
    logic [7:0] paddr, c;
    logic [31:0] pwdata, prdata, rd;
    logic [2:0] irq_ack, irq;
    int errors, check_count, cycles;

    tcc_top DUT (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .external_count_pin(ext_pin), .irq_ack(irq_ack), .irq(irq),
        .compare_output_a(pin_a), .compare_output_a_oe_n(oe_n_a),
        .compare_output_b(pin_b), .compare_output_b_oe_n(oe_n_b));
    tcc_pins_model far (.pclk(pclk), .pin_a(pin_a), .oe_n_a(oe_n_a), .level_a(level_a),
        .external_count_pin(ext_pin));

    always #50 pclk = ~pclk;

    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        check_count++;
        if (got !== exp) begin
            errors++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask

    // ==========================================
    // APB master: one idle edge before each setup
    task automatic apb(input logic w, input logic [7:0] a, input logic [7:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= {24'h000000, d};
        @(posedge pclk);
        penable <= 1'b1;
        // Waits as long as it takes; only the cycle ceiling ends a hang
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        rd = prdata;
        last_err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        apb(1'b1, a, d);
    endtask

    task automatic rdx(input string what, input logic [7:0] a, input logic [7:0] exp);
        apb(1'b0, a, 8'h00);
        chk(what, {24'h000000, exp}, rd);
    endtask

    // Run the timer on pclk for a short burst
    task automatic run();
        wr(`TCC_OFS_CTRL_B, 8'h01);
        repeat (4) @(posedge pclk);
        wr(`TCC_OFS_CTRL_B, 8'h00);
    endtask

    task automatic final_report();
        $display("Checks %0d, errors %0d", check_count, errors);
        if (errors == 0 && check_count > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    always @(posedge pclk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            errors++;
            final_report();
        end
    end

    initial begin
        pclk = 1'b0;
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h00000000;
        irq_ack = 3'h0;
        errors = 0;
        check_count = 0;
        cycles = 0;
        c = 8'($urandom(32'h22810f68));
        repeat (5) @(posedge pclk);
        presetn <= 1'b1;
        for (int i = 0; i < 9; i++) begin
            rdx("reset value", 8'(i * 4), 8'h00);
        end
        chk("pin a at reset", 32'h2, {30'h0, oe_n_a, pin_a});
        chk("pin b at reset", 32'h2, {30'h0, oe_n_b, pin_b});
        apb(1'b0, 8'h24, 8'h00);
        chk("unmapped error", 32'h1, {31'h0, last_err});
        chk("unmapped data", 32'h0, rd);
        repeat (4) begin
            c = 8'($urandom);
            wr(`TCC_OFS_COUNT, c);
            rdx("stopped count", `TCC_OFS_COUNT, c);
        end
        wr(`TCC_OFS_POWER, 8'h01);
        run();
        rdx("powered off count", `TCC_OFS_COUNT, c);
        wr(`TCC_OFS_POWER, 8'h00);
        wr(`TCC_OFS_CMP_A, 8'h80);
        wr(`TCC_OFS_CMP_B, 8'h90);
        wr(`TCC_OFS_COUNT, 8'hFE);
        run();
        apb(1'b0, `TCC_OFS_COUNT, 8'h00);
        chk("count wrapped", 32'h1, {31'h0, rd[7:0] < 8'h20});
        rdx("overflow flag", `TCC_OFS_FLAG, 8'h01);
        wr(`TCC_OFS_FLAG, 8'h01);
        rdx("flag written one", `TCC_OFS_FLAG, 8'h00);
        c = 8'($urandom_range(8'hF0, 8'h10));
        wr(`TCC_OFS_CMP_A, c);
        wr(`TCC_OFS_CMP_B, c ^ 8'h80);
        wr(`TCC_OFS_COUNT, c - 8'h03);
        run();
        rdx("compare a flag", `TCC_OFS_FLAG, 8'h02);
        wr(`TCC_OFS_MASK, 8'h02);
        repeat (2) @(posedge pclk);
        chk("irq enabled", 32'h2, {29'h0, irq});
        wr(`TCC_OFS_MASK, 8'h05);
        repeat (2) @(posedge pclk);
        chk("irq masked", 32'h0, {29'h0, irq});
        irq_ack <= 3'b010;
        @(posedge pclk);
        irq_ack <= 3'b000;
        rdx("flag after ack", `TCC_OFS_FLAG, 8'h00);
        wr(`TCC_OFS_CMP_B, 8'h20);
        wr(`TCC_OFS_CMP_A, 8'hA0);
        wr(`TCC_OFS_COUNT, 8'h20);
        run();
        rdx("blocked match", `TCC_OFS_FLAG, 8'h00);
        wr(`TCC_OFS_CTRL_A, 8'h03);
        wr(`TCC_OFS_CMP_A, 8'h52);
        wr(`TCC_OFS_COUNT, 8'h50);
        run();
        rdx("buffered compare", `TCC_OFS_FLAG, 8'h00);
        wr(`TCC_OFS_CTRL_A, 8'h40);
        wr(`TCC_OFS_CTRL_B, 8'h80);
        repeat (3) @(posedge pclk);
        chk("pin a released", 32'h1, {31'h0, level_a});
        rdx("force sets no flag", `TCC_OFS_FLAG, 8'h00);
        wr(`TCC_OFS_PORT, 8'h04);
        repeat (3) @(posedge pclk);
        chk("pin a forced", 32'h1, {30'h0, oe_n_a, pin_a});
        wr(`TCC_OFS_CTRL_A, 8'h00);
        repeat (3) @(posedge pclk);
        chk("pin a port data", 32'h0, {31'h0, pin_a});
        wr(`TCC_OFS_CTRL_B, 8'h80);
        wr(`TCC_OFS_CTRL_A, 8'h42);
        repeat (3) @(posedge pclk);
        chk("latch kept", 32'h1, {31'h0, pin_a});
        // Clear on match: 0,1,2,3 then back to 0, seven ticks end at 3
        wr(`TCC_OFS_CMP_A, 8'h03);
        wr(`TCC_OFS_COUNT, 8'h00);
        run();
        rdx("ctc count", `TCC_OFS_COUNT, 8'h03);
        rdx("ctc flag", `TCC_OFS_FLAG, 8'h02);
        chk("ctc toggle", 32'h0, {31'h0, pin_a});
        wr(`TCC_OFS_CTRL_A, 8'h30);
        wr(`TCC_OFS_CTRL_B, 8'h40);
        wr(`TCC_OFS_PORT, 8'h08);
        repeat (3) @(posedge pclk);
        chk("pin b forced", 32'h1, {30'h0, oe_n_b, pin_b});
        wr(`TCC_OFS_CTRL_A, 8'h00);
        wr(`TCC_OFS_COUNT, 8'h00);
        wr(`TCC_OFS_CTRL_B, 8'h07);
        far.pulses(5);
        repeat (10) @(posedge pclk);
        wr(`TCC_OFS_CTRL_B, 8'h00);
        rdx("external count", `TCC_OFS_COUNT, 8'h05);
        final_report();
    end
endmodule
